/* ddrcap_clkbuf.sv */
// Forwarded-clock conditioner: synchroniser, edge finder and lane stage
`timescale 1ns/1ps
`default_nettype none
module ddrcap_clkbuf
    import ddrcap_pkg::*;
#(
    parameter bit REGIONAL = 1'b0,
    parameter bit ALIGNED  = 1'b0
) (
    input  wire logic           mclk,
    input  wire logic           arst,
    input  wire logic           link_clk,
    output ddrcap_strobe_t      strobe
);

    localparam int DLY = (REGIONAL ? LANE_STAGES : 0)
                       + (ALIGNED ? ALIGN_CYC : 0);

    localparam logic [1:0] WARM_END = 2'(SYNC_STAGES + EDGE_STAGES);

    logic           clk_s1;
    logic           clk_s2;
    logic           clk_s3;
    logic [1:0]     warm;
    ddrcap_strobe_t pipe [DLY:0];

    // Edges count only once the chain holds real pin levels: a link clock
    // that is high at reset release must not pass for a rising edge
    always_ff @(posedge mclk or posedge arst) begin
        if (arst) begin
            warm <= '0;
        end else if (warm != WARM_END) begin
            warm <= warm + 2'h1;
        end
    end

    always_ff @(posedge mclk or posedge arst) begin
        if (arst) begin
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
        end else begin
            clk_s1 <= link_clk;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
        end
    end

    // Global path: the edge register is the buffer feeding capture, through the centering offset in aligned mode
    always_ff @(posedge mclk or posedge arst) begin
        if (arst) begin
            pipe[0] <= '0;
        end else begin
            pipe[0].rise <= (warm == WARM_END) & clk_s2 & ~clk_s3;
            pipe[0].fall <= (warm == WARM_END) & ~clk_s2 & clk_s3;
        end
    end

    // Lane skew stage plus aligned-mode centering offset
    genvar g;
    generate
        for (g = 1; g <= DLY; g++) begin : g_dly
            always_ff @(posedge mclk or posedge arst) begin
                if (arst) begin
                    pipe[g] <= '0;
                end else begin
                    pipe[g] <= pipe[g-1];
                end
            end
        end
    endgenerate

    assign strobe = pipe[DLY];

endmodule : ddrcap_clkbuf
`default_nettype wire

/* ddrcap_pkg.sv */
// Shared constants and types for the double-rate receive capture block
package ddrcap_pkg;

    // Sampling clock and link timing
    localparam int MCLK_PERIOD_NS = 8;
    localparam int LINK_PERIOD_NS = 64;
    // Half of one data bit window, used as the aligned-mode centering offset
    localparam int HALF_UI_NS     = LINK_PERIOD_NS / 4;
    localparam int ALIGN_CYC      =
        (HALF_UI_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    // Depth of every pin synchroniser
    localparam int SYNC_STAGES    = 2;
    // Extra stage through the lane skew controller on the regional path
    localparam int LANE_STAGES    = 1;
    // Edge register that sits after the clock synchroniser
    localparam int EDGE_STAGES    = 1;

    // Capacity limits
    localparam int GLOBAL_MAX_BITS   = 128;
    localparam int REGIONAL_MAX_BITS = 11;
    localparam int GLOBAL_MAX_SE     = 12;
    localparam int GLOBAL_MAX_DIFF   = 6;
    localparam int REGIONAL_MAX_SE   = 11;
    localparam int REGIONAL_MAX_DIFF = 5;

    // Word bits per input: twice the gearing ratio (2, 3.5, 4, 5) or 2 for x1
    localparam int WB_X1   = 2;
    localparam int WB_X2   = 4;
    localparam int WB_X3P5 = 7;
    localparam int WB_X4   = 8;
    localparam int WB_X5   = 10;

    localparam int CNT_W   = 4;

    typedef enum logic [0:0] {
        DDRCAP_HUNT = 1'b0,
        DDRCAP_RUN  = 1'b1
    } ddrcap_gear_t;

    // Sampling strobes derived from the forwarded clock
    typedef struct packed {
        logic rise;
        logic fall;
    } ddrcap_strobe_t;

endpackage : ddrcap_pkg

/* ddrcap_rx.sv */
// Double-rate receive capture with optional gearing into fabric words
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Even word bits carry rising-edge samples, odd bits falling-edge, until a bit slip or an odd word width swaps them.
// - Total input width up to 128 global or 11 regional.
// - Gearing ratios 2, 3.5, 4 or 5 deserialise each input.
// - Word bits per input equal twice the gearing ratio.
// - Gear-by-four word holds four beats in pairs 1:0, 3:2, 5:4, 7:6.
// - Fixed data delay matches clock insertion up to the capture flop, except for the aligned-mode centering offset on the clock.
// - Global variant clocks capture and fabric from the global buffer.
// - Regional variant passes the clock through a lane skew stage.
// - Geared data reaches the fabric domain without loss or user sync.
// - Global carries 12 single or 6 differential inputs, regional 11 or 5.
// - Pause pulse resets gearing, re-synchronises and drops bit-slip.
// - Active-low asynchronous reset clears capture and lane logic.
module ddrcap_rx
    import ddrcap_pkg::*;
#(
    parameter int N_INPUTS     = 1,
    parameter int WORD_BITS    = WB_X4,
    parameter bit REGIONAL     = 1'b0,
    parameter bit ALIGNED      = 1'b0,
    parameter bit DIFFERENTIAL = 1'b0
) (
    input  wire logic                            mclk,
    input  wire logic                            rst,
    input  wire logic                            async_reset_low,
    input  wire logic                            link_clk,
    input  wire logic [N_INPUTS-1:0]             link_data,
    input  wire logic                            fast_clock_pause_pulse,
    input  wire logic                            bit_slip,
    output logic      [N_INPUTS*WORD_BITS-1:0]   rx_word,
    output logic                                 rx_word_valid,
    output logic                                 lane_fabric_clock
);

    localparam int W        = N_INPUTS * WORD_BITS;
    localparam int DATA_DLY = EDGE_STAGES + (REGIONAL ? LANE_STAGES : 0);
    localparam int MAX_BITS = REGIONAL ? REGIONAL_MAX_BITS : GLOBAL_MAX_BITS;
    localparam int MAX_PINS = REGIONAL
        ? (DIFFERENTIAL ? REGIONAL_MAX_DIFF : REGIONAL_MAX_SE)
        : (DIFFERENTIAL ? GLOBAL_MAX_DIFF : GLOBAL_MAX_SE);
    localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(WORD_BITS - 1);
    localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'((WORD_BITS + 1) / 2);

    generate
        if (N_INPUTS < 1 || N_INPUTS > MAX_BITS) begin : g_bad_width
            $error("ddrcap_rx: N_INPUTS exceeds the clock network limit");
        end
        if (N_INPUTS > MAX_PINS) begin : g_bad_pins
            $error("ddrcap_rx: too many data inputs for this variant");
        end
        if (WORD_BITS != WB_X1 && WORD_BITS != WB_X2 && WORD_BITS != WB_X3P5
            && WORD_BITS != WB_X4 && WORD_BITS != WB_X5) begin : g_bad_gear
            $error("ddrcap_rx: unsupported gearing ratio");
        end
    endgenerate

    // Either reset acts at once, with no clock needed
    logic arst;
    assign arst = rst | ~async_reset_low;

    ddrcap_strobe_t strobe;

    ddrcap_clkbuf #(
        .REGIONAL (REGIONAL),
        .ALIGNED  (ALIGNED)
    ) u_clkbuf (
        .mclk     (mclk),
        .arst     (arst),
        .link_clk (link_clk),
        .strobe   (strobe)
    );

    // Data synchroniser and static input delay
    logic [N_INPUTS-1:0] dat_s1;
    logic [N_INPUTS-1:0] dat_s2;
    logic [N_INPUTS-1:0] dpipe [DATA_DLY:0];

    always_ff @(posedge mclk or posedge arst) begin
        if (arst) begin
            dat_s1 <= '0;
            dat_s2 <= '0;
        end else begin
            dat_s1 <= link_data;
            dat_s2 <= dat_s1;
        end
    end

    assign dpipe[0] = dat_s2;

    genvar g;
    generate
        for (g = 1; g <= DATA_DLY; g++) begin : g_static_input_delay
            always_ff @(posedge mclk or posedge arst) begin
                if (arst) begin
                    dpipe[g] <= '0;
                end else begin
                    dpipe[g] <= dpipe[g-1];
                end
            end
        end
    endgenerate

    logic [N_INPUTS-1:0] sample;
    assign sample = dpipe[DATA_DLY];

    // Pause and slip pins cross in through two flops, then an edge finder
    logic pause_s1;
    logic pause_s2;
    logic pause_s3;
    logic slip_s1;
    logic slip_s2;
    logic slip_s3;

    always_ff @(posedge mclk or posedge arst) begin
        if (arst) begin
            pause_s1 <= 1'b0;
            pause_s2 <= 1'b0;
            pause_s3 <= 1'b0;
            slip_s1  <= 1'b0;
            slip_s2  <= 1'b0;
            slip_s3  <= 1'b0;
        end else begin
            pause_s1 <= fast_clock_pause_pulse;
            pause_s2 <= pause_s1;
            pause_s3 <= pause_s2;
            slip_s1  <= bit_slip;
            slip_s2  <= slip_s1;
            slip_s3  <= slip_s2;
        end
    end

    logic pause_evt;
    logic slip_evt;
    // Pause counts either edge, since that pin is toggled rather than held; slip counts rising edges only
    assign pause_evt = pause_s2 ^ pause_s3;
    assign slip_evt  = slip_s2 & ~slip_s3;

    // Writes one sample of every input into its slot of the word
    function automatic logic [W-1:0] place(
        input logic [W-1:0]        word,
        input logic [N_INPUTS-1:0] bits,
        input logic [CNT_W-1:0]    slot
    );
        logic [W-1:0] res;
        res = word;
        for (int i = 0; i < N_INPUTS; i++) begin
            res[i*WORD_BITS + int'(slot)] = bits[i];
        end
        return res;
    endfunction : place

    ddrcap_gear_t     state;
    logic [CNT_W-1:0] cnt;
    logic [W-1:0]     shreg;
    logic             slip_pend;
    logic [W-1:0]     next_shreg;
    logic             take;

    assign take       = (strobe.rise | strobe.fall) & ~slip_pend;
    assign next_shreg = place(shreg, sample, cnt);

    // Slip request: swallow one sample to move the word boundary
    always_ff @(posedge mclk or posedge arst) begin
        if (arst) begin
            slip_pend <= 1'b0;
        end else if (pause_evt) begin
            slip_pend <= 1'b0;
        end else if (slip_evt && state == DDRCAP_RUN) begin
            slip_pend <= 1'b1;
        end else if (strobe.rise | strobe.fall) begin
            slip_pend <= 1'b0;
        end
    end

    // Gearing state: the first group after reset or pause opens on a rising-edge sample
    always_ff @(posedge mclk or posedge arst) begin
        if (arst) begin
            state <= DDRCAP_HUNT;
            cnt   <= '0;
            shreg <= '0;
        end else if (pause_evt) begin
            state <= DDRCAP_HUNT;
            cnt   <= '0;
        end else begin
            unique case (state)
                DDRCAP_HUNT: begin
                    if (strobe.rise) begin
                        shreg <= place(shreg, sample, '0);
                        cnt   <= CNT_W'(1);
                        state <= DDRCAP_RUN;
                    end
                end
                DDRCAP_RUN: begin
                    if (take) begin
                        shreg <= next_shreg;
                        cnt   <= (cnt == LAST_CNT) ? '0 : cnt + CNT_W'(1);
                    end
                end
            endcase
        end
    end

    // Whole word moves to the output register in one step, so the fabric
    // never sees bits of two groups mixed together
    always_ff @(posedge mclk or posedge arst) begin
        if (arst) begin
            rx_word       <= '0;
            rx_word_valid <= 1'b0;
        end else begin
            rx_word_valid <= 1'b0;
            if (!pause_evt && state == DDRCAP_RUN && take
                && cnt == LAST_CNT) begin
                rx_word       <= next_shreg;
                rx_word_valid <= 1'b1;
            end
        end
    end

    // Divided fabric clock: rises with each new word, falls halfway through
    always_ff @(posedge mclk or posedge arst) begin
        if (arst) begin
            lane_fabric_clock <= 1'b0;
        end else if (pause_evt || state == DDRCAP_HUNT) begin
            lane_fabric_clock <= 1'b0;
        end else if (take && cnt == LAST_CNT) begin
            lane_fabric_clock <= 1'b1;
        end else if (take && cnt == HALF_CNT - CNT_W'(1)) begin
            lane_fabric_clock <= 1'b0;
        end
    end

endmodule : ddrcap_rx
`default_nettype wire

/* ddrcap_rx_monitor.sv */
// Port checks for the double-rate capture block
`timescale 1ns/1ps
`default_nettype none
module ddrcap_rx_monitor
    import ddrcap_pkg::*;
#(
    parameter int N_INPUTS  = 1,
    parameter int WORD_BITS = WB_X4
) (
    input wire logic                    mclk,
    input wire logic                    rst,
    input wire logic                    async_reset_low,
    input wire logic                    link_clk,
    input wire logic [N_INPUTS-1:0]     link_data,
    input wire logic                    fast_clock_pause_pulse,
    input wire logic                    bit_slip,
    input wire logic [N_INPUTS*WORD_BITS-1:0] rx_word,
    input wire logic                    rx_word_valid,
    input wire logic                    lane_fabric_clock
);
    logic       any_rst;
    logic       link_q;
    logic [7:0] gap;
    logic [7:0] since_edge;
    assign any_rst = rst | ~async_reset_low;
    // Saturating counts, so a long idle span never wraps into a false pass
    always_ff @(posedge mclk or posedge any_rst) begin
        if (any_rst) gap <= 8'hff;
        else if (rx_word_valid) gap <= 8'h00;
        else if (gap != 8'hff) gap <= gap + 8'h01;
    end
    always_ff @(posedge mclk or posedge any_rst) begin
        if (any_rst) begin
            link_q     <= 1'b0;
            since_edge <= 8'hff;
        end else begin
            link_q <= link_clk;
            if (link_clk != link_q) since_edge <= 8'h00;
            else if (since_edge != 8'hff) since_edge <= since_edge + 8'h01;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (any_rst);
    property p_valid_pulse; rx_word_valid |=> !rx_word_valid; endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("word valid longer than one cycle");
    property p_word_hold; !rx_word_valid |-> $stable(rx_word); endproperty
    a_word_hold: assert property (p_word_hold)
        else $error("word changed without valid");
    property p_reset_clear;
        disable iff (1'b0) any_rst |-> rx_word == '0 && !rx_word_valid
            && !lane_fabric_clock;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("outputs not cleared in reset");
    property p_reset_quiet; $fell(rst) |-> !rx_word_valid [*8]; endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("word too soon after reset");
    property p_pause_quiet;
        $changed(fast_clock_pause_pulse) |-> ##8 !rx_word_valid [*8];
    endproperty
    a_pause_quiet: assert property (p_pause_quiet)
        else $error("word too soon after pause");
    property p_spacing;
        rx_word_valid |-> gap >= 8'(3 * WORD_BITS - 1);
    endproperty
    a_spacing: assert property (p_spacing)
        else $error("words closer than one full group");
    property p_fab_rise;
        rx_word_valid |-> lane_fabric_clock && !$past(lane_fabric_clock);
    endproperty
    a_fab_rise: assert property (p_fab_rise)
        else $error("fabric clock not rising with word");
    property p_link_cause; rx_word_valid |-> since_edge < 8'h08; endproperty
    a_link_cause: assert property (p_link_cause)
        else $error("word without recent link edge");
endmodule : ddrcap_rx_monitor
bind ddrcap_rx ddrcap_rx_monitor #(
    .N_INPUTS(N_INPUTS), .WORD_BITS(WORD_BITS)
) ddrcap_rx_monitor_i (
    .mclk(mclk), .rst(rst), .async_reset_low(async_reset_low),
    .link_clk(link_clk), .link_data(link_data),
    .fast_clock_pause_pulse(fast_clock_pause_pulse), .bit_slip(bit_slip),
    .rx_word(rx_word), .rx_word_valid(rx_word_valid),
    .lane_fabric_clock(lane_fabric_clock));
`default_nettype wire

/* ddrcap_rx_tb_top.sv */
// Bench: random centered stream with slip, pause and reset
`timescale 1ns/1ps
`default_nettype none
module ddrcap_rx_tb_top;
    import ddrcap_pkg::*;
    logic        mclk;
    logic        rst;
    logic        async_reset_low;
    logic        link_clk;
    logic        link_data;
    logic        fast_clock_pause_pulse;
    logic        bit_slip;
    logic [7:0]  rx_word;
    logic        rx_word_valid;
    logic        lane_fabric_clock;
    logic [15:0] lfsr;
    int          miscompares;
    int          n_checks;
    int          ptr;
    int          snap;
    ddrcap_tx_model tx_i (.link_clk(link_clk), .link_data(link_data));
    ddrcap_rx ddrcap_rx_i (
        .mclk(mclk), .rst(rst), .async_reset_low(async_reset_low),
        .link_clk(link_clk), .link_data(link_data),
        .fast_clock_pause_pulse(fast_clock_pause_pulse),
        .bit_slip(bit_slip), .rx_word(rx_word),
        .rx_word_valid(rx_word_valid), .lane_fabric_clock(lane_fabric_clock));
    function automatic logic [15:0] lfsr_next(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    function automatic logic [7:0] exp_word(int p);
        logic [7:0] w;
        for (int k = 0; k < 8; k++) w[k] = tx_i.sent[p + k];
        return w;
    endfunction : exp_word
    task automatic cmp_word(logic [7:0] got, logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic next_word(output logic [7:0] w);
        int n;
        n = 0;
        while (rx_word_valid !== 1'b1 && n < 300) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 300) miscompares++;
        snap = tx_i.sent.size();
        w = rx_word;
        @(posedge mclk);
        #1;
    endtask : next_word
    // The group just closed ends at the stream's newest edge: the word
    // appears three mclk after that edge, the next edge comes after four
    task automatic align(bit need_rise);
        logic [7:0] w;
        next_word(w);
        ptr = snap;
        cmp_word(w, exp_word(ptr - 8));
        if (need_rise) begin
            cmp_word({7'h00, tx_i.sent_rise[ptr - 8]}, 8'h01);
        end
    endtask : align
    task automatic check_words(int n);
        logic [7:0] w;
        repeat (n) begin
            next_word(w);
            cmp_word(w, exp_word(ptr));
            ptr += 8;
        end
    endtask : check_words
    task automatic wrap_up();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        lfsr = 16'hdde8;
        forever begin
            @(negedge mclk);
            if (tx_i.q.size() < 2) begin
                lfsr = lfsr_next(lfsr);
                tx_i.q.push_back(lfsr[0]);
            end
        end
    end
    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end
    initial begin
        logic [7:0] w;
        rst = 1'b1;
        async_reset_low = 1'b1;
        fast_clock_pause_pulse = 1'b0;
        bit_slip = 1'b0;
        miscompares = 0;
        n_checks = 0;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        align(1'b1);
        check_words(5);
        for (int i = 0; i < 2; i++) begin
            @(negedge mclk) bit_slip = 1'b1;
            @(negedge mclk) bit_slip = 1'b0;
            next_word(w);
            align(1'b0);
            cmp_word({7'h00, tx_i.sent_rise[ptr - 8]}, 8'h00);
            check_words(2);
            @(negedge mclk) fast_clock_pause_pulse = ~fast_clock_pause_pulse;
            repeat (10) @(posedge mclk);
            #1;
            align(1'b1);
            check_words(2);
        end
        @(negedge mclk) async_reset_low = 1'b0;
        #1;
        cmp_word(rx_word, 8'h00);
        cmp_word({7'h00, rx_word_valid | lane_fabric_clock}, 8'h00);
        repeat (2) @(negedge mclk);
        async_reset_low = 1'b1;
        align(1'b1);
        check_words(3);
        wrap_up();
    end
endmodule : ddrcap_rx_tb_top
`default_nettype wire

/* ddrcap_tx_model.sv */
// Centered double-rate transmitter with a free-running forwarded clock
`timescale 1ns/1ps
`default_nettype none
module ddrcap_tx_model (
    output logic link_clk,
    output logic link_data
);
    logic q[$];
    logic sent[$];
    logic sent_rise[$];
    initial begin
        link_clk  = 1'b0;
        link_data = 1'b0;
        #3.3;
        forever begin
            #16;
            // Starved queue toggles, so stale data never looks valid
            link_data = (q.size() != 0) ? q.pop_front() : ~link_data;
            #16;
            link_clk = ~link_clk;
            sent.push_back(link_data);
            sent_rise.push_back(link_clk);
        end
    end
endmodule : ddrcap_tx_model
`default_nettype wire
